// [rtl/priority_crossbar_port_io.sv]
// priority crossbar decoder and port i/o cell control
// Functional notes
// - each enabled signal takes lowest free pin
// - assigned pins are passed over afterwards
// - skipped pins count as already occupied
// - async serial fixed on P0.4 and P0.5
// - two-wire and async claim both pins
// - leftover pins stay ordinary port i/o
// - routing P0.0-P1.7; gpio P0.0-P2.1
// - sync serial three pins, four with select
// - two-wire output pin order follows swap bit; inputs unswapped
// - after reset cells hi-z with pull-up
// - crossbar disabled: drivers off on crossbar pins
// - input-mode one digital, zero analog, resets digital
// - analog pin: pull-up, driver, receiver off
// - latch read gives zero on analog pins
// - output-mode one: push-pull drive
// - output-mode zero: open-drain
// - pull-up on when hi-z, global disable
// - digital pin reads pad level
// - fixed functions see digital pins only
// - per-port drive strength, default high
// - routing only once crossbar enabled
// - two-wire pins always open-drain
`timescale 1ns/1ps
module priority_crossbar_port_io
    import xbar_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire routing_sel_t       routing_sel,
    input  wire logic               crossbar_enable,
    input  wire logic               weak_pullup_disable,
    input  wire logic [1:0]         slave_select_mode,
    input  wire logic               two_wire_swap,
    input  wire logic [15:0]        pin_skip_mask,
    input  wire logic               cfg_we,
    input  wire logic [17:0]        input_mode_select_wr,
    input  wire logic [17:0]        output_mode_select_wr,
    input  wire logic [2:0]         drive_strength_select_wr,
    input  wire logic               latch_we,
    input  wire logic [17:0]        port_latch_wr,
    input  wire logic [NUM_SLOTS-1:0] periph_out,
    input  wire logic               async_tx_out,
    input  wire logic [17:0]        pad_in,
    output pad_ctl_t                pad_ctl,
    output logic [2:0]              drive_strength,
    output logic [17:0]             port_latch_rd,
    output logic [17:0]             fixed_func_in,
    output logic [NUM_SLOTS-1:0]    periph_in,
    output logic                    async_rx_in,
    output logic [15:0]             pin_assigned
);
    logic [17:0] input_mode_select_r;
    logic [17:0] output_mode_select_r;
    logic [2:0]  drive_strength_r;
    logic [17:0] latch_r;
    logic [17:0] pad_s1_r;
    logic [17:0] pad_s2_r;
    logic [NUM_SLOTS-1:0] want;
    logic [NUM_XBAR_PINS-1:0] busy [0:NUM_SLOTS];
    logic [NUM_XBAR_PINS-1:0] grant [0:NUM_SLOTS-1];
    logic [NUM_XBAR_PINS-1:0] tw_pins;
    logic [NUM_XBAR_PINS-1:0] grant_any;
    logic [17:0] od_val;
    logic [17:0] od_en_n;
    logic [17:0] pu_nxt;
    logic [17:0] rx_nxt;
    logic [NUM_SLOTS-1:0] pin_in_nxt;
    logic [15:0] assigned_nxt;
    logic        rx_nxt_async;
    logic        en_r;

    // configuration registers, digital mode after reset
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            input_mode_select_r  <= RST_INPUT_MODE;
            output_mode_select_r <= RST_OUTPUT_MODE;
            drive_strength_r     <= RST_DRIVE;
        end
        else if (cfg_we)
        begin
            input_mode_select_r  <= input_mode_select_wr;
            output_mode_select_r <= output_mode_select_wr;
            drive_strength_r     <= drive_strength_select_wr;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            latch_r <= RST_LATCH;
        else if (latch_we)
            latch_r <= port_latch_wr;
    end

    // pads are outside the clock domain: two stages before use
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pad_s1_r <= '0;
            pad_s2_r <= '0;
        end
        else
        begin
            pad_s1_r <= pad_in;
            pad_s2_r <= pad_s1_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            en_r <= 1'b0;
        else
            en_r <= crossbar_enable;
    end

    // request vector in fixed priority order
    always_comb
    begin
        want = '0;
        want[SIG_SCK]    = routing_sel.sync_serial_en;
        want[SIG_MISO]   = routing_sel.sync_serial_en;
        want[SIG_MOSI]   = routing_sel.sync_serial_en;
        // select line routed only in 4-wire slave-select modes
        want[SIG_SSEL]   = routing_sel.sync_serial_en
                         & (slave_select_mode != 2'h0);
        want[SIG_TW_A]   = routing_sel.two_wire_en;
        want[SIG_TW_B]   = routing_sel.two_wire_en;
        want[SIG_CMP0]   = routing_sel.cmp0_en;
        want[SIG_CMP0A]  = routing_sel.cmp0a_en;
        want[SIG_CMP1]   = routing_sel.cmp1_en;
        want[SIG_CMP1A]  = routing_sel.cmp1a_en;
        want[SIG_SYSCLK] = routing_sel.sysclk_en;
        want[SIG_CEX0]   = routing_sel.counter_array_sel != 2'h0;
        want[SIG_CEX1]   = routing_sel.counter_array_sel[1];
        want[SIG_CEX2]   = routing_sel.counter_array_sel == 2'h3;
        want[SIG_ECI]    = routing_sel.external_count_input_en;
        want[SIG_T0]     = routing_sel.t0_en;
        want[SIG_T1]     = routing_sel.t1_en;
        want[SIG_T2]     = routing_sel.t2_en;
        if (!en_r)
            want = '0;
    end

    // skipped pins and fixed async pins start out busy
    always_comb
    begin
        busy[0] = pin_skip_mask;
        if (routing_sel.async_serial_en && en_r)
        begin
            busy[0][ASYNC_TX_PIN] = 1'b1;
            busy[0][ASYNC_RX_PIN] = 1'b1;
        end
    end

    // chain of allocators, one per signal slot
    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++)
        begin : g_alloc
            pin_alloc #(
                .PINS     (NUM_XBAR_PINS)
            ) u_alloc (
                .busy_in  (busy[g]),
                .want     (want[g]),
                .busy_out (busy[g+1]),
                .grant    (grant[g])
            );
        end
    endgenerate

    // build cell controls
    always_comb
    begin
        od_val       = latch_r; // gpio default source
        tw_pins      = grant[SIG_TW_A] | grant[SIG_TW_B];
        grant_any    = '0;
        assigned_nxt = busy[NUM_SLOTS] & ~pin_skip_mask;
        for (int p = 0; p < NUM_XBAR_PINS; p++)
        begin
            for (int s = 0; s < NUM_SLOTS; s++)
            begin
                if (grant[s][p])
                begin
                    grant_any[p] = 1'b1;
                    // swap exchanges data and clock on the pair
                    if (s == SIG_TW_A || s == SIG_TW_B)
                        od_val[p] = periph_out[(s == SIG_TW_A)
                            ^ two_wire_swap ? SIG_TW_A : SIG_TW_B];
                    else
                        od_val[p] = periph_out[s];
                end
            end
        end
        if (routing_sel.async_serial_en && en_r)
        begin
            od_val[ASYNC_TX_PIN] = async_tx_out;
            od_val[ASYNC_RX_PIN] = 1'b1;
        end
        for (int p = 0; p < 18; p++)
        begin
            if (!input_mode_select_r[p])
                od_en_n[p] = 1'b1;
            else if (p < NUM_XBAR_PINS && !en_r)
                od_en_n[p] = 1'b1;
            else if (p == ASYNC_RX_PIN && routing_sel.async_serial_en)
                od_en_n[p] = 1'b1;
            else if (p < NUM_XBAR_PINS && tw_pins[p])
                od_en_n[p] = od_val[p];
            else if (output_mode_select_r[p])
                od_en_n[p] = 1'b0;
            else
                od_en_n[p] = od_val[p];
            // pull-up only on an undriven digital cell
            pu_nxt[p] = input_mode_select_r[p] & od_en_n[p]
                      & ~weak_pullup_disable;
            rx_nxt[p] = input_mode_select_r[p];
        end
        pin_in_nxt = '0;
        for (int s = 0; s < NUM_SLOTS; s++)
        begin
            for (int p = 0; p < NUM_XBAR_PINS; p++)
            begin
                if (grant[s][p] && input_mode_select_r[p])
                    pin_in_nxt[s] = pad_s2_r[p];
            end
        end
        rx_nxt_async = pad_s2_r[ASYNC_RX_PIN]
                     & input_mode_select_r[ASYNC_RX_PIN];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pad_ctl.out_en_n  <= '1;
            pad_ctl.out_val   <= '1;
            pad_ctl.pullup_on <= '1;
            pad_ctl.rx_en     <= '1;
            drive_strength    <= RST_DRIVE;
            pin_assigned      <= '0;
        end
        else
        begin
            pad_ctl.out_en_n  <= od_en_n;
            pad_ctl.out_val   <= od_val;
            pad_ctl.pullup_on <= pu_nxt;
            pad_ctl.rx_en     <= rx_nxt;
            drive_strength    <= drive_strength_r;
            pin_assigned      <= assigned_nxt;
        end
    end

    // read side: pad levels, zero for analog cells, async receive held high when its pin is analog
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            port_latch_rd <= '0;
            fixed_func_in <= '0;
            periph_in     <= '0;
            async_rx_in   <= 1'b1;
        end
        else
        begin
            port_latch_rd <= pad_s2_r & input_mode_select_r;
            fixed_func_in <= pad_s2_r & input_mode_select_r;
            periph_in     <= pin_in_nxt;
            async_rx_in   <= rx_nxt_async | ~input_mode_select_r[ASYNC_RX_PIN];
        end
    end

    property p_analog_reads_zero;
        @(posedge clk) disable iff (sys_rst)
        !input_mode_select_r[0] |=> !port_latch_rd[0] || $changed(input_mode_select_r[0]);
    endproperty
    a_analog_reads_zero: assert property (p_analog_reads_zero)
        else $error("analog pin read nonzero");

    property p_disabled_off;
        @(posedge clk) disable iff (sys_rst)
        !en_r |=> (&pad_ctl.out_en_n[15:0]) || $rose(en_r);
    endproperty
    a_disabled_off: assert property (p_disabled_off)
        else $error("driver on while crossbar off");

    property p_async_fixed;
        @(posedge clk) disable iff (sys_rst)
        routing_sel.async_serial_en && en_r |=> pad_ctl.out_en_n[ASYNC_RX_PIN]
            && pad_ctl.out_val[ASYNC_TX_PIN] == $past(async_tx_out);
    endproperty
    a_async_fixed: assert property (p_async_fixed)
        else $error("async pins not reserved");

    property p_skip_never_granted;
        @(posedge clk) disable iff (sys_rst)
        (grant_any & pin_skip_mask) == '0;
    endproperty
    a_skip_never_granted: assert property (p_skip_never_granted)
        else $error("skipped pin assigned");

    property p_pullup_low;
        @(posedge clk) disable iff (sys_rst)
        !pad_ctl.out_en_n[6] && !pad_ctl.out_val[6] |-> !pad_ctl.pullup_on[6];
    endproperty
    a_pullup_low: assert property (p_pullup_low)
        else $error("pull-up on while driving low");

    property p_two_wire_pair;
        @(posedge clk) disable iff (sys_rst)
        routing_sel.two_wire_en && en_r |-> want[SIG_TW_A] && want[SIG_TW_B];
    endproperty
    a_two_wire_pair: assert property (p_two_wire_pair)
        else $error("two-wire pins not claimed together");

    property p_analog_off;
        @(posedge clk) disable iff (sys_rst)
        !input_mode_select_r[3] |=> pad_ctl.out_en_n[3] && !pad_ctl.rx_en[3];
    endproperty
    a_analog_off: assert property (p_analog_off)
        else $error("analog cell not isolated");

    property p_lowest_first;
        @(posedge clk) disable iff (sys_rst)
        want[SIG_SCK] && !busy[0][0] |-> grant[SIG_SCK][0];
    endproperty
    a_lowest_first: assert property (p_lowest_first)
        else $error("lowest free pin not chosen");
endmodule

// [rtl/xbar_pkg.sv]
// shared constants and carrier types for the crossbar and port cells
package xbar_pkg;
    localparam int NUM_XBAR_PINS  = 16;
    localparam int NUM_GPIO_PINS  = 18;
    localparam int NUM_PORTS      = 3;
    localparam int NUM_SIGS       = 17;
    localparam int ASYNC_TX_PIN   = 4;
    localparam int ASYNC_RX_PIN   = 5;
    // signal slots in priority order below the asynchronous serial unit
    localparam int SIG_SCK        = 0;
    localparam int SIG_MISO       = 1;
    localparam int SIG_MOSI       = 2;
    localparam int SIG_SSEL       = 3;
    localparam int SIG_TW_A       = 4;
    localparam int SIG_TW_B       = 5;
    localparam int SIG_CMP0       = 6;
    localparam int SIG_CMP0A      = 7;
    localparam int SIG_CMP1       = 8;
    localparam int SIG_CMP1A      = 9;
    localparam int SIG_SYSCLK     = 10;
    localparam int SIG_CEX0       = 11;
    localparam int SIG_CEX1       = 12;
    localparam int SIG_CEX2       = 13;
    localparam int SIG_ECI        = 14;
    localparam int SIG_T0         = 15;
    localparam int SIG_T1         = 16;
    localparam logic [17:0] RST_INPUT_MODE  = 18'h3FFFF;
    localparam logic [17:0] RST_OUTPUT_MODE = 18'h00000;
    localparam logic [17:0] RST_LATCH       = 18'h3FFFF;
    localparam logic [2:0]  RST_DRIVE       = 3'h7;
    // timer 2 takes the last slot
    localparam int SIG_T2         = 17;
    localparam int NUM_SLOTS      = 18;

    typedef struct packed {
        logic       async_serial_en;
        logic       sync_serial_en;
        logic       two_wire_en;
        logic       cmp0_en;
        logic       cmp0a_en;
        logic       cmp1_en;
        logic       cmp1a_en;
        logic       sysclk_en;
        logic [1:0] counter_array_sel;
        logic       external_count_input_en;
        logic       t0_en;
        logic       t1_en;
        logic       t2_en;
    } routing_sel_t;

    typedef struct packed {
        logic [17:0] out_en_n;
        logic [17:0] out_val;
        logic [17:0] pullup_on;
        logic [17:0] rx_en;
    } pad_ctl_t;
endpackage

// [rtl/pin_alloc.sv]
// one stage of the priority pin allocator: places one signal
`timescale 1ns/1ps
module pin_alloc
    import xbar_pkg::*;
#(
    parameter int PINS = 16
)
(
    input  wire logic [PINS-1:0] busy_in,
    input  wire logic            want,
    output logic      [PINS-1:0] busy_out,
    output logic      [PINS-1:0] grant
);
    always_comb
    begin
        grant = '0;
        if (want)
        begin
            for (int i = PINS - 1; i >= 0; i--)
            begin
                if (!busy_in[i])
                begin
                    grant = '0;
                    grant[i] = 1'b1;
                end
            end
        end
        busy_out = busy_in | grant;
    end
endmodule

// [verif/pad_board_model.sv]
// board side of the pads: device drivers, board drivers, weak pull-ups
`timescale 1ns/1ps
module pad_board_model
    import xbar_pkg::*;
(
    input  wire logic        clk,
    input  wire pad_ctl_t    pad_ctl,
    input  wire logic [17:0] ext_en,
    input  wire logic [17:0] ext_val,
    output logic      [17:0] pad_in
);
    // a floating pad has no stable level; toggling stops tests leaning on it
    logic [17:0] float_r = 18'h2AAAA;

    always_ff @(posedge clk)
        float_r <= ~float_r;

    always_comb
    begin
        for (int i = 0; i < 18; i++)
        begin
            if (!pad_ctl.out_en_n[i])
                pad_in[i] = pad_ctl.out_val[i];
            else if (ext_en[i])
                pad_in[i] = ext_val[i];
            else if (pad_ctl.pullup_on[i])
                pad_in[i] = 1'b1;
            else
                pad_in[i] = float_r[i];
        end
    end
endmodule

// [verif/priority_crossbar_port_io_test.sv]
// self-checking bench for the crossbar and port cell control
`timescale 1ns/1ps
module priority_crossbar_port_io_test;
    import xbar_pkg::*;
    logic                 clk;
    logic                 sys_rst;
    routing_sel_t         routing_sel;
    logic                 crossbar_enable;
    logic                 weak_pullup_disable;
    logic [1:0]           slave_select_mode;
    logic                 two_wire_swap;
    logic [15:0]          pin_skip_mask;
    logic                 cfg_we;
    logic [17:0]          in_mode;
    logic [17:0]          out_mode;
    logic [2:0]           drive_wr;
    logic                 latch_we;
    logic [17:0]          latch_wr;
    logic [NUM_SLOTS-1:0] periph_out;
    logic                 async_tx_out;
    logic [17:0]          pad_in;
    pad_ctl_t             pad_ctl;
    logic [2:0]           drive_strength;
    logic [17:0]          port_latch_rd;
    logic [17:0]          fixed_func_in;
    logic [NUM_SLOTS-1:0] periph_in;
    logic                 async_rx_in;
    logic [15:0]          pin_assigned;
    logic [17:0]          ext_en;
    logic [17:0]          ext_val;
    int                   bad_count;
    int                   cmp_count;
    logic [13:0]          rt_sel  [5] = '{14'h3000, 14'h3400, 14'h04FF,
                                          14'h0400, 14'h0800};
    logic [15:0]          rt_skip [5] = '{16'h0008, 16'h0000, 16'h0000,
                                          16'h7FFF, 16'h0003};
    logic [1:0]           rt_ssm  [5] = '{2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
    logic [15:0]          rt_exp  [5] = '{16'h0077, 16'h003F, 16'h03FF,
                                          16'h8000, 16'h000C};
    logic [9:0]           pat = 10'h2CA;

    priority_crossbar_port_io DUT (.clk(clk), .sys_rst(sys_rst),
        .routing_sel(routing_sel), .crossbar_enable(crossbar_enable),
        .weak_pullup_disable(weak_pullup_disable),
        .slave_select_mode(slave_select_mode), .two_wire_swap(two_wire_swap),
        .pin_skip_mask(pin_skip_mask), .cfg_we(cfg_we),
        .input_mode_select_wr(in_mode), .output_mode_select_wr(out_mode),
        .drive_strength_select_wr(drive_wr), .latch_we(latch_we),
        .port_latch_wr(latch_wr), .periph_out(periph_out),
        .async_tx_out(async_tx_out), .pad_in(pad_in), .pad_ctl(pad_ctl),
        .drive_strength(drive_strength), .port_latch_rd(port_latch_rd),
        .fixed_func_in(fixed_func_in), .periph_in(periph_in),
        .async_rx_in(async_rx_in), .pin_assigned(pin_assigned));

    pad_board_model board (.clk(clk), .pad_ctl(pad_ctl), .ext_en(ext_en),
        .ext_val(ext_val), .pad_in(pad_in));

    initial clk = 1'b0;
    always #4 clk = ~clk;

    // inputs always move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // pad_ctl lags a write by 2 edges, pad reads by 5
    task automatic cfg_write(input logic [17:0] im, input logic [17:0] om,
                             input logic [2:0] dr);
        cfg_we = 1'b1;
        in_mode = im;
        out_mode = om;
        drive_wr = dr;
        tick(1);
        cfg_we = 1'b0;
        tick(6);
    endtask

    task automatic latch_write(input logic [17:0] v);
        latch_we = 1'b1;
        latch_wr = v;
        tick(1);
        latch_we = 1'b0;
        tick(6);
    endtask

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic note(input string name);
        $display("test %s done", name);
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        summarize();
    end

    initial
    begin
        bad_count = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        routing_sel = '0;
        crossbar_enable = 1'b0;
        weak_pullup_disable = 1'b0;
        slave_select_mode = 2'h0;
        two_wire_swap = 1'b0;
        pin_skip_mask = 16'h0000;
        cfg_we = 1'b0;
        in_mode = 18'h3FFFF;
        out_mode = 18'h00000;
        drive_wr = 3'h7;
        latch_we = 1'b0;
        latch_wr = 18'h3FFFF;
        periph_out = '1;
        async_tx_out = 1'b1;
        ext_en = 18'h00000;
        ext_val = 18'h00000;
        tick(4);
        chk(pad_ctl.out_en_n, 18'h3FFFF);
        chk(pad_ctl.pullup_on, 18'h3FFFF);
        chk(pad_ctl.rx_en, 18'h3FFFF);
        chk({15'h0, drive_strength}, 18'h00007);
        tick(1);
        sys_rst = 1'b0;
        tick(6);
        chk(port_latch_rd, 18'h3FFFF);
        note("reset");
        // routing asked for but crossbar still off
        routing_sel = routing_sel_t'(14'h3000);
        cfg_write(18'h3FFFF, 18'h3FFFF, 3'h7);
        latch_write(18'h00000);
        chk({2'h0, pad_ctl.out_en_n[15:0]}, 18'h0FFFF);
        chk({2'h0, pin_assigned}, 18'h00000);
        note("disabled");
        routing_sel = '0;
        crossbar_enable = 1'b1;
        tick(6);
        chk(pad_ctl.out_en_n, 18'h00000);
        chk(pad_ctl.pullup_on, 18'h00000);
        chk(port_latch_rd, 18'h00000);
        latch_write(18'h3FFFF);
        chk(pad_ctl.out_val, 18'h3FFFF);
        ext_en = 18'h00080;
        cfg_write(18'h3FFFF, 18'h00000, 3'h7);
        chk(pad_ctl.out_en_n, 18'h3FFFF);
        chk(pad_ctl.pullup_on, 18'h3FFFF);
        chk(port_latch_rd, 18'h3FF7F);
        weak_pullup_disable = 1'b1;
        tick(6);
        chk(pad_ctl.pullup_on, 18'h00000);
        weak_pullup_disable = 1'b0;
        ext_en = 18'h00000;
        latch_write(18'h3FFFE);
        chk(pad_ctl.out_en_n, 18'h3FFFE);
        chk(pad_ctl.pullup_on, 18'h3FFFE);
        latch_write(18'h3FFFF);
        note("port cells");
        for (int k = 0; k < 5; k++)
        begin
            routing_sel = routing_sel_t'(rt_sel[k]);
            pin_skip_mask = rt_skip[k];
            slave_select_mode = rt_ssm[k];
            tick(6);
            chk({2'h0, pin_assigned}, {2'h0, rt_exp[k]});
        end
        note("placement");
        // board drives a pattern on pins 0..9, every cell released
        routing_sel = routing_sel_t'(14'h04FF);
        pin_skip_mask = 16'h0000;
        ext_en = 18'h003FF;
        ext_val = {8'h00, pat};
        tick(6);
        chk(periph_in & 18'h3FE40, {pat[9:1], 2'b00, pat[0], 6'h00});
        note("priority");
        routing_sel = routing_sel_t'(14'h3000);
        pin_skip_mask = 16'h0008;
        slave_select_mode = 2'h1;
        async_tx_out = 1'b0;
        ext_en = 18'h00020;
        ext_val = 18'h00000;
        cfg_write(18'h3FFFF, 18'h3FFFF, 3'h7);
        chk({14'h0, async_rx_in, pad_ctl.out_en_n[5:4], pad_ctl.out_val[4]},
            18'h00004);
        async_tx_out = 1'b1;
        ext_en = 18'h00000;
        note("async serial");
        routing_sel = routing_sel_t'(14'h0800);
        pin_skip_mask = 16'h0003;
        periph_out = ~(18'h00001 << SIG_TW_A);
        tick(6);
        chk({16'h0, pad_ctl.out_en_n[3:2]}, 18'h00002);
        two_wire_swap = 1'b1;
        tick(6);
        chk({16'h0, pad_ctl.out_en_n[3:2]}, 18'h00001);
        periph_out = '1;
        note("two wire");
        // pin 0 analog and skipped, board pulls it high
        routing_sel = '0;
        pin_skip_mask = 16'hFFFF;
        ext_en = 18'h00001;
        ext_val = 18'h00001;
        cfg_write(18'h3FFFE, 18'h3FFFF, 3'h2);
        latch_write(18'h00002);
        chk({11'h0, pad_ctl.out_en_n[0], pad_ctl.pullup_on[0],
            pad_ctl.rx_en[0], port_latch_rd[1:0], fixed_func_in[1:0]},
            18'h0004A);
        chk({15'h0, drive_strength}, 18'h00002);
        note("analog");
        summarize();
    end
endmodule
